//--- core/i2c_control_config.sv
// The Wishbone interface to the registers was left to the implementer.
`include "i2c_control_config_map.svh"
`timescale 1ns/10ps
`default_nettype none

module i2c_control_config (
   input  wire logic                          I_MCLK,
   input  wire logic                          I_SYS_RST,
   input  wire logic                          i_CYC_I,
   input  wire logic                          i_STB_I,
   input  wire logic                          i_WE_I,
   input  wire logic [7:0]                    i_ADR_I,
   input  wire logic [3:0]                    i_SEL_I,
   input  wire logic [31:0]                   i_DAT_I,
   output logic      [31:0]                   o_DAT_O,
   output logic                               o_ACK_O,
   input  wire logic                          i_SCL,
   input  wire logic                          i_SDA,
   input  wire logic                          i_RX_FULL,
   input  wire logic                          i_RX_BYTE_DONE,
   input  wire logic                          i_TX_LOW,
   input  wire logic                          i_TX_BUSY,
   output logic                               o_SCL_OUT,
   output logic                               o_SCL_OE,
   output logic                               o_XFER_GO,
   output i2c_control_config_pkg::xfer_type   o_XFER,
   output logic                               o_IRQ
);
   import i2c_control_config_pkg::*;

   // ****************************************************************
   // register state
   // ****************************************************************
   ctrl_type       ctrl_q;
   logic           enable_q;
   logic [6:0]     own_addr_q;
   logic [31:0]    mask_q;
   logic [31:0]    raw_q;
   logic           ack_q;
   logic [31:0]    rdata_q;

   // ****************************************************************
   // bus decode
   // ****************************************************************
   logic           bus_req;
   logic           bus_wr;
   logic [31:0]    wmask;
   logic [31:0]    wdata;
   logic [31:0]    ctrl_word;
   logic [31:0]    ctrl_next;

   // one access per request, ack drops the cycle after it rose
   assign bus_req = i_CYC_I & i_STB_I & ~ack_q;
   assign bus_wr  = bus_req & i_WE_I;
   assign wmask   = {{8{i_SEL_I[3]}}, {8{i_SEL_I[2]}}, {8{i_SEL_I[1]}}, {8{i_SEL_I[0]}}};
   assign wdata   = i_DAT_I & wmask;

   // control fields laid out at their bit positions
   // read-only zero
   always_comb begin
      ctrl_word                             = 32'h00000000;
      ctrl_word[`CCFG_BIT_MASTER_EN]        = ctrl_q.master_enable;
      ctrl_word[`CCFG_BIT_WIDE_ADDR]        = ctrl_q.master_wide_addressing;
      ctrl_word[`CCFG_BIT_RESTART]          = ctrl_q.repeated_start_allow;
      ctrl_word[`CCFG_BIT_TGT_OFF]          = ctrl_q.target_function_off;
      ctrl_word[`CCFG_BIT_STOP_ADDR]        = ctrl_q.stop_irq_only_addressed;
      ctrl_word[`CCFG_BIT_TXE_CTRL]         = ctrl_q.txe_controlled;
      ctrl_word[`CCFG_BIT_RX_HOLD]          = ctrl_q.receive_full_hold_bus;
      ctrl_word[`CCFG_BIT_STOP_MACT]        = 1'b0;
   end

   // merge of old value and byte-lane write
   assign ctrl_next = (ctrl_word & ~wmask) | wdata;

   // ****************************************************************
   // control register
   // ****************************************************************
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         ctrl_q.target_function_off     <= 1'b1;
         ctrl_q.repeated_start_allow    <= 1'b1;
         ctrl_q.master_enable           <= 1'b1;
         ctrl_q.master_wide_addressing  <= 1'b0;
         ctrl_q.stop_irq_only_addressed <= 1'b0;
         ctrl_q.txe_controlled          <= 1'b0;
         ctrl_q.receive_full_hold_bus   <= 1'b0;
      end else if (bus_wr && i_ADR_I == `CCFG_OFS_CONTROL && !enable_q) begin
         // software pairs bits 6 and 0; stored as written
         ctrl_q.master_enable           <= ctrl_next[`CCFG_BIT_MASTER_EN];
         ctrl_q.master_wide_addressing  <= ctrl_next[`CCFG_BIT_WIDE_ADDR];
         ctrl_q.repeated_start_allow    <= ctrl_next[`CCFG_BIT_RESTART];
         ctrl_q.target_function_off     <= ctrl_next[`CCFG_BIT_TGT_OFF];
         ctrl_q.stop_irq_only_addressed <= ctrl_next[`CCFG_BIT_STOP_ADDR];
         ctrl_q.txe_controlled          <= ctrl_next[`CCFG_BIT_TXE_CTRL];
         ctrl_q.receive_full_hold_bus   <= ctrl_next[`CCFG_BIT_RX_HOLD];
      end
   end

   // enable, own address and mask registers
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         enable_q   <= 1'b0;
         own_addr_q <= `CCFG_OWN_ADDR_RESET;
         mask_q     <= 32'h00000000;
      end else if (bus_wr) begin
         if (i_ADR_I == `CCFG_OFS_ENABLE && i_SEL_I[0]) begin
            enable_q <= i_DAT_I[0];
         end
         // own address follows the same lock as control
         if (i_ADR_I == `CCFG_OFS_OWN_ADDR && i_SEL_I[0] && !enable_q) begin
            own_addr_q <= i_DAT_I[6:0];
         end
         if (i_ADR_I == `CCFG_OFS_IRQ_MASK) begin
            mask_q <= ((mask_q & ~wmask) | wdata) & `CCFG_IRQ_ALL;
         end
      end
   end

   // ****************************************************************
   // link input synchronisers
   // ****************************************************************
   logic [1:0]     scl_sync_q;
   logic [1:0]     sda_sync_q;
   logic           scl_last_q;
   logic           sda_last_q;
   logic           scl_rise;
   logic           start_seen;
   logic           stop_seen;

   // two flops per pin; only stage 1 feeds logic
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         scl_sync_q <= 2'b11;
         sda_sync_q <= 2'b11;
         scl_last_q <= 1'b1;
         sda_last_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], i_SCL};
         sda_sync_q <= {sda_sync_q[0], i_SDA};
         scl_last_q <= scl_sync_q[1];
         sda_last_q <= sda_sync_q[1];
      end
   end

   // data edge while clock high marks start or stop
   assign scl_rise   = scl_sync_q[1] & ~scl_last_q;
   assign start_seen = scl_sync_q[1] & scl_last_q & sda_last_q & ~sda_sync_q[1];
   assign stop_seen  = scl_sync_q[1] & scl_last_q & ~sda_last_q & sda_sync_q[1];

   // ****************************************************************
   // target address capture
   // ****************************************************************
   tgt_state_type  tgt_q;
   logic [3:0]     bit_cnt_q;
   logic [7:0]     shift_q;
   logic           own_hit_q;

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         tgt_q       <= TGT_IDLE;
         bit_cnt_q   <= 4'h0;
         shift_q     <= 8'h00;
         own_hit_q   <= 1'b0;
      end else if (ctrl_q.target_function_off || !enable_q || stop_seen) begin
         tgt_q       <= TGT_IDLE;
         bit_cnt_q   <= 4'h0;
         // stop qualifier reads the match before this clear lands
         own_hit_q   <= 1'b0;
      end else if (start_seen) begin
         // repeated start keeps an earlier match alive
         tgt_q     <= TGT_ADDR;
         bit_cnt_q <= 4'h0;
      end else begin
         case (tgt_q)
            TGT_IDLE: begin
               bit_cnt_q <= 4'h0;
            end
            TGT_ADDR: begin
               if (scl_rise) begin
                  shift_q   <= {shift_q[6:0], sda_sync_q[1]};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
               if (bit_cnt_q == `CCFG_BITS_PER_BYTE) begin
                  tgt_q <= TGT_DATA;
                  // general call is an own match only when own_addr_q is 0
                  if (shift_q[7:1] == own_addr_q) begin
                     own_hit_q <= 1'b1;
                  end
               end
            end
            TGT_DATA: begin
               bit_cnt_q <= 4'h0;
            end
            default: begin
               tgt_q <= TGT_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // master transfer planning
   // ****************************************************************
   logic           cmd_wr;
   logic           forbidden;
   logic           abort_evt;

   assign cmd_wr = bus_wr && i_ADR_I == `CCFG_OFS_XFER_CMD && i_SEL_I[0] && enable_q && ctrl_q.master_enable;

   // operations that need a repeated start
   assign forbidden = !ctrl_q.repeated_start_allow &&
                      (i_DAT_I[`CCFG_CMD_START_BYTE] || i_DAT_I[`CCFG_CMD_HIGH_SPEED] ||
                       i_DAT_I[`CCFG_CMD_DIR_CHANGE] ||
                       (i_DAT_I[`CCFG_CMD_READ] && ctrl_q.master_wide_addressing));
   assign abort_evt = cmd_wr & forbidden;

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         o_XFER_GO <= 1'b0;
         o_XFER    <= '0;
      end else begin
         o_XFER_GO <= cmd_wr & ~forbidden;
         if (cmd_wr && !forbidden) begin
            o_XFER.read    <= i_DAT_I[`CCFG_CMD_READ];
            o_XFER.wide    <= ctrl_q.master_wide_addressing;
            o_XFER.restart <= i_DAT_I[`CCFG_CMD_COMBINED] & ctrl_q.repeated_start_allow;
            o_XFER.split   <= i_DAT_I[`CCFG_CMD_COMBINED] & ~ctrl_q.repeated_start_allow;
         end
      end
   end

   // ****************************************************************
   // receive-full hold and interrupt sources
   // ****************************************************************
   logic           hold_now;
   logic           txe_level;
   logic           stop_evt;
   logic [31:0]    set_vec;
   logic [31:0]    clr_vec;
   logic [31:0]    raw_view;

   // hold only when enabled in control
   assign hold_now  = ctrl_q.receive_full_hold_bus & i_RX_FULL & enable_q;
   // controlled mode also waits for shifter idle
   assign txe_level = enable_q & i_TX_LOW & (~ctrl_q.txe_controlled | ~i_TX_BUSY);
   assign stop_evt  = stop_seen & enable_q & (~ctrl_q.stop_irq_only_addressed | own_hit_q);

   always_comb begin
      set_vec                      = 32'h00000000;
      set_vec[`CCFG_IRQ_RX_OVER]   = i_RX_BYTE_DONE & i_RX_FULL & ~hold_now;
      set_vec[`CCFG_IRQ_TX_ABORT]  = abort_evt;
      set_vec[`CCFG_IRQ_STOP]      = stop_evt;
   end

   assign clr_vec = (bus_wr && i_ADR_I == `CCFG_OFS_RAW_IRQ) ? (wdata & `CCFG_IRQ_STICKY) : 32'h00000000;

   // sticky bits; a set in the clearing cycle wins
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         raw_q <= 32'h00000000;
      end else begin
         raw_q <= ((raw_q & ~clr_vec) | set_vec) & `CCFG_IRQ_STICKY;
      end
   end

   // transmit-empty is a live level, not sticky
   always_comb begin
      raw_view                      = raw_q;
      raw_view[`CCFG_IRQ_TX_EMPTY]  = txe_level;
   end

   // hold drives clock low through the open-drain enable
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         o_SCL_OUT <= 1'b0;
         o_SCL_OE  <= 1'b0;
         o_IRQ     <= 1'b0;
      end else begin
         o_SCL_OUT <= 1'b0;
         o_SCL_OE  <= hold_now;
         o_IRQ     <= |(raw_view & mask_q);
      end
   end

   // ****************************************************************
   // read mux and acknowledge
   // ****************************************************************
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q <= bus_req;
         if (bus_req && !i_WE_I) begin
            case (i_ADR_I)
               `CCFG_OFS_CONTROL:  rdata_q <= ctrl_word;
               `CCFG_OFS_OWN_ADDR: rdata_q <= {25'h0000000, own_addr_q};
               `CCFG_OFS_IRQ_MASK: rdata_q <= mask_q;
               `CCFG_OFS_RAW_IRQ:  rdata_q <= raw_view;
               `CCFG_OFS_ENABLE:   rdata_q <= {31'h00000000, enable_q};
               default:            rdata_q <= 32'h00000000;
            endcase
         end else begin
            rdata_q <= 32'h00000000;
         end
      end
   end

   assign o_ACK_O = ack_q;
   assign o_DAT_O = rdata_q;

endmodule

`default_nettype wire

//--- core/i2c_control_config_map.svh
`ifndef I2C_CONTROL_CONFIG_MAP_SVH
`define I2C_CONTROL_CONFIG_MAP_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define CCFG_OFS_CONTROL     8'h00
`define CCFG_OFS_OWN_ADDR    8'h08
`define CCFG_OFS_IRQ_MASK    8'h30
`define CCFG_OFS_RAW_IRQ     8'h34
`define CCFG_OFS_ENABLE      8'h6C
`define CCFG_OFS_XFER_CMD    8'hB0

// ****************************************************************
// control register fields
// ****************************************************************
`define CCFG_BIT_MASTER_EN   0
`define CCFG_BIT_WIDE_ADDR   4
`define CCFG_BIT_RESTART     5
`define CCFG_BIT_TGT_OFF     6
`define CCFG_BIT_STOP_ADDR   7
`define CCFG_BIT_TXE_CTRL    8
`define CCFG_BIT_RX_HOLD     9
`define CCFG_BIT_STOP_MACT   10
`define CCFG_CONTROL_RESET   32'h00000061
`define CCFG_CONTROL_WMASK   32'h000003F1

// ****************************************************************
// interrupt status bits
// ****************************************************************
`define CCFG_IRQ_RX_OVER     1
`define CCFG_IRQ_TX_EMPTY    4
`define CCFG_IRQ_TX_ABORT    6
`define CCFG_IRQ_STOP        9
`define CCFG_IRQ_STICKY      32'h00000242
`define CCFG_IRQ_ALL         32'h00000252

// ****************************************************************
// transfer command fields
// ****************************************************************
`define CCFG_CMD_READ        0
`define CCFG_CMD_START_BYTE  1
`define CCFG_CMD_HIGH_SPEED  2
`define CCFG_CMD_COMBINED    3
`define CCFG_CMD_DIR_CHANGE  4

// ****************************************************************
// link constants
// ****************************************************************
`define CCFG_GENERAL_CALL    7'h00
`define CCFG_OWN_ADDR_RESET  7'h55
`define CCFG_BITS_PER_BYTE   4'h8

`endif

//--- core/i2c_control_config_pkg.sv
package i2c_control_config_pkg;

   // software-visible control fields
   typedef struct packed {
      logic receive_full_hold_bus;
      logic txe_controlled;
      logic stop_irq_only_addressed;
      logic target_function_off;
      logic repeated_start_allow;
      logic master_wide_addressing;
      logic master_enable;
   } ctrl_type;

   // transfer plan handed to the bus engine
   typedef struct packed {
      logic read;
      logic wide;
      logic restart;
      logic split;
   } xfer_type;

   // target-side address capture, gray along the path
   typedef enum logic [1:0] {
      TGT_IDLE = 2'b00,
      TGT_ADDR = 2'b01,
      TGT_DATA = 2'b11
   } tgt_state_type;

endpackage

//--- dv/i2c_control_config_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// *****
// port protocol checks
// *****
module i2c_control_config_assertions (
   input wire logic                         I_MCLK,
   input wire logic                         I_SYS_RST,
   input wire logic                         i_CYC_I,
   input wire logic                         i_STB_I,
   input wire logic                         i_WE_I,
   input wire logic [7:0]                   i_ADR_I,
   input wire logic [31:0]                  i_DAT_I,
   input wire logic                         i_RX_FULL,
   input wire logic [31:0]                  o_DAT_O,
   input wire logic                         o_ACK_O,
   input wire logic                         o_SCL_OE,
   input wire logic                         o_XFER_GO,
   input wire i2c_control_config_pkg::xfer_type o_XFER,
   input wire logic                         o_IRQ
);
   import i2c_control_config_pkg::*;
   // one domain, so clock and reset are given once
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);
   a_ack_after_req: assert property (i_CYC_I && i_STB_I && !o_ACK_O |=> o_ACK_O ##1 !o_ACK_O)
      else $error("ack missing or too long");
   a_data_idle_zero: assert property (!o_ACK_O |-> o_DAT_O == 32'h00000000)
      else $error("read data outside ack");
   a_ctrl_reserved_zero: assert property (
      o_ACK_O && i_CYC_I && !i_WE_I && i_ADR_I == 8'h00 |-> o_DAT_O[31:10] == 22'h0 && o_DAT_O[3:1] == 3'h0)
      else $error("control reserved bits not zero");
   a_go_from_cmd: assert property (o_XFER_GO |-> $past(i_CYC_I && i_STB_I && i_WE_I && i_ADR_I == 8'hB0))
      else $error("transfer started without command");
   a_split_restart: assert property (o_XFER_GO |-> (o_XFER.split || o_XFER.restart) == $past(i_DAT_I[3]) && !(o_XFER.split && o_XFER.restart))
      else $error("split flag disagrees with restart");
   a_no_wide_read: assert property (o_XFER_GO && o_XFER.split |-> !(o_XFER.read && o_XFER.wide))
      else $error("wide read started without restart");
   a_hold_needs_full: assert property ($rose(o_SCL_OE) |-> $past(i_RX_FULL) || $past(i_RX_FULL, 2))
      else $error("clock held without full receive");
   a_hold_release: assert property ($fell(i_RX_FULL) |-> ##[1:3] !o_SCL_OE)
      else $error("clock hold not released");
   a_reset_quiet: assert property ($past(I_SYS_RST) |-> !o_ACK_O && !o_IRQ && !o_XFER_GO && !o_SCL_OE)
      else $error("outputs active after reset");
endmodule
bind i2c_control_config i2c_control_config_assertions u_chk (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST),
   .i_CYC_I(i_CYC_I), .i_STB_I(i_STB_I), .i_WE_I(i_WE_I), .i_ADR_I(i_ADR_I), .i_DAT_I(i_DAT_I),
   .i_RX_FULL(i_RX_FULL),
   .o_DAT_O(o_DAT_O), .o_ACK_O(o_ACK_O), .o_SCL_OE(o_SCL_OE), .o_XFER_GO(o_XFER_GO), .o_XFER(o_XFER),
   .o_IRQ(o_IRQ));
`default_nettype wire

//--- dv/i2c_bus_peer.sv
`timescale 1ns/10ps
`default_nettype none
// *****
// far-side bus master stand-in
// *****
module i2c_bus_peer #(
   parameter int HALF_NS = 400
) (
   output logic o_scl,
   output logic o_sda
);
   // lines pulled up, so released lines read high
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // start, address msb first, ack slot, stop; clock still outside frames
   task automatic send_frame(input logic [7:0] addr_byte);
      int i;
      // small offset keeps every line change off the system clock edges
      #(HALF_NS + 13) o_sda = 1'b0;
      for (i = 8; i >= 0; i--) begin
         #(HALF_NS) o_scl = 1'b0;
         #(HALF_NS / 2) o_sda = (i > 0) ? addr_byte[i - 1] : 1'b0;
         #(HALF_NS / 2) o_scl = 1'b1;
      end
      #(HALF_NS) o_sda = 1'b1;
      #(HALF_NS);
   endtask
endmodule
`default_nettype wire

//--- dv/i2c_control_config_tb_top.sv
`timescale 1ns/10ps
`include "i2c_control_config_map.svh"
`default_nettype none
module i2c_control_config_tb_top;
   import i2c_control_config_pkg::*;
   logic        mclk, sys_rst, cyc, stb, we, rx_full, rx_done, tx_low, tx_busy;
   logic        ack, scl_out, scl_oe, go, irq, peer_scl, peer_sda, go_seen, scl_line;
   logic [7:0]  adr;
   logic [3:0]  sel, lanes;
   logic [31:0] wdat, rdat, rval, seed;
   logic [31:0] cfg [3];
   xfer_type    xfer, xfer_seen;
   int          err_count, comparisons, i, k;
   // *****
   // clock, design and far side
   // *****
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   i2c_control_config uut (.I_MCLK(mclk), .I_SYS_RST(sys_rst), .i_CYC_I(cyc), .i_STB_I(stb), .i_WE_I(we),
      .i_ADR_I(adr), .i_SEL_I(sel), .i_DAT_I(wdat), .o_DAT_O(rdat), .o_ACK_O(ack), .i_SCL(scl_line),
      .i_SDA(peer_sda), .i_RX_FULL(rx_full), .i_RX_BYTE_DONE(rx_done), .i_TX_LOW(tx_low),
      .i_TX_BUSY(tx_busy), .o_SCL_OUT(scl_out), .o_SCL_OE(scl_oe), .o_XFER_GO(go), .o_XFER(xfer), .o_IRQ(irq));
   i2c_bus_peer peer (.o_scl(peer_scl), .o_sda(peer_sda));
   // wired-and clock line: the design pulls low while holding
   assign scl_line = peer_scl & ~scl_oe;
   // expectation helpers
   function automatic logic [31:0] lfsr_next(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic forbidden(logic [31:0] cmd, logic [31:0] ctl);
      return !ctl[5] && (cmd[1] || cmd[2] || cmd[4] || (cmd[0] && ctl[4]));
   endfunction
   function automatic logic [31:0] plan_exp(logic [31:0] cmd, logic [31:0] ctl);
      return {28'h0, cmd[0], ctl[4], cmd[3] & ctl[5], cmd[3] & ~ctl[5]};
   endfunction
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one classic cycle, request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      {cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, lanes, d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1);
      rval = rdat;
      go_seen = go;
      xfer_seen = xfer;
      {cyc, stb} <= 2'b00;
      // registered ack: seen high at the second edge after the request
      chk("ack wait", 32'(n), 32'h2);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      wb(1'b0, a, 32'h0);
      chk(name, rval, exp);
   endtask
   // control can only change while disabled, so drop enable around it
   task automatic setup(input logic [31:0] ctl);
      wb(1'b1, `CCFG_OFS_ENABLE, 32'h0);
      wb(1'b1, `CCFG_OFS_CONTROL, ctl);
      wb(1'b1, `CCFG_OFS_ENABLE, 32'h1);
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog, far beyond the fewer than one thousand cycles the run needs
   initial begin
      #(100 * 20000);
      err_count++;
      finish_test();
   end
   // *****
   // main sequence
   // *****
   initial begin
      {cyc, stb, we, rx_full, rx_done, tx_low, tx_busy} = 7'h00;
      {adr, sel, wdat} = 44'h0;
      lanes = 4'hF;
      sys_rst = 1'b1;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(`CCFG_OFS_CONTROL, 32'h61, "ctrl reset");
      rd(`CCFG_OFS_OWN_ADDR, 32'h55, "own addr reset");
      wb(1'b1, 8'hFC, 32'hFFFFFFFF);
      rd(8'hFC, 32'h0, "unmapped");
      seed = 32'h000151C2;
      for (i = 0; i < 8; i++) begin
         seed = lfsr_next(seed);
         if (!seed[6]) seed[0] = 1'b0;
         wb(1'b1, `CCFG_OFS_CONTROL, seed);
         rd(`CCFG_OFS_CONTROL, seed & 32'h3F1, "ctrl rand");
      end
      wb(1'b1, `CCFG_OFS_CONTROL, 32'hFFFFFFFF);
      rd(`CCFG_OFS_CONTROL, 32'h3F1, "ctrl ro bit");
      // only byte lane 1 written: bits 9 and 8 clear, the rest stay
      lanes = 4'h2;
      wb(1'b1, `CCFG_OFS_CONTROL, 32'h0);
      lanes = 4'hF;
      rd(`CCFG_OFS_CONTROL, 32'hF1, "ctrl lane");
      wb(1'b1, `CCFG_OFS_ENABLE, 32'h1);
      wb(1'b1, `CCFG_OFS_CONTROL, 32'h0);
      rd(`CCFG_OFS_CONTROL, 32'hF1, "ctrl locked");
      // every command bit under restart off, wide restart off, restart on
      cfg = '{32'h41, 32'h51, 32'h71};
      for (i = 0; i < 3; i++) begin
         setup(cfg[i]);
         for (k = 0; k < 5; k++) begin
            wb(1'b1, `CCFG_OFS_XFER_CMD, 32'h1 << k);
            chk("go", 32'(go_seen), 32'(!forbidden(32'h1 << k, cfg[i])));
            if (go_seen === 1'b1) chk("plan", 32'(xfer_seen), plan_exp(32'h1 << k, cfg[i]));
            rd(`CCFG_OFS_RAW_IRQ, {25'h0, forbidden(32'h1 << k, cfg[i]), 6'h0}, "abort");
            wb(1'b1, `CCFG_OFS_RAW_IRQ, 32'h40);
         end
      end
      // stop events: always, general call, own, other, target off
      wb(1'b1, `CCFG_OFS_IRQ_MASK, 32'h200);
      for (i = 0; i < 5; i++) begin
         setup(i == 0 ? 32'h20 : (i == 4 ? 32'hE0 : 32'hA0));
         peer.send_frame(i == 2 || i == 4 ? 8'hAA : (i == 3 ? 8'hA8 : 8'h00));
         rd(`CCFG_OFS_RAW_IRQ, 32'(i % 2 == 0 && i < 4) << 9, "stop flag");
         chk("irq", 32'(irq), 32'(i % 2 == 0 && i < 4));
         wb(1'b1, `CCFG_OFS_IRQ_MASK, 32'h0);
         // irq is registered one cycle behind the mask
         @(posedge mclk);
         chk("irq masked", 32'(irq), 32'h0);
         wb(1'b1, `CCFG_OFS_IRQ_MASK, 32'h200);
         wb(1'b1, `CCFG_OFS_RAW_IRQ, 32'h200);
      end
      // receive full: hold, hold with target off, overflow
      cfg = '{32'h220, 32'h260, 32'h020};
      for (i = 0; i < 3; i++) begin
         setup(cfg[i]);
         rx_full <= 1'b1;
         repeat (4) @(posedge mclk);
         chk("hold", 32'(scl_oe), 32'(i != 2));
         chk("scl drive", 32'(scl_out), 32'h0);
         rx_done <= 1'b1;
         @(posedge mclk);
         rx_done <= 1'b0;
         rd(`CCFG_OFS_RAW_IRQ, i == 2 ? 32'h2 : 32'h0, "overflow");
         wb(1'b1, `CCFG_OFS_RAW_IRQ, 32'h2);
         rx_full <= 1'b0;
      end
      // transmit empty in both modes, shifter busy or idle
      tx_low <= 1'b1;
      for (i = 0; i < 4; i++) begin
         tx_busy <= i[0];
         setup(i[1] ? 32'h160 : 32'h060);
         rd(`CCFG_OFS_RAW_IRQ, (i == 3) ? 32'h0 : 32'h10, "tx empty");
      end
      finish_test();
   end
endmodule
`default_nettype wire
